// File: include/emsc_pkg.sv
package emsc_pkg;

    // ****************************************************************
    // Timing and frame limits
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned HB_WINDOW_NS    = 4000;
    localparam int unsigned HB_WINDOW_CYC   =
        (HB_WINDOW_NS / CLK_PERIOD_NS) > 0 ? HB_WINDOW_NS / CLK_PERIOD_NS : 1;
    localparam logic [15:0] MAX_FRAME_BYTES = 16'd1518;
    localparam logic [15:0] MIN_FRAME_BYTES = 16'd64;
    localparam logic [9:0]  LATE_COLL_BITS  = 10'd512;
    localparam logic [4:0]  MAX_COLL        = 5'd16;
    localparam int unsigned HIST_BINS       = 15;

    // ****************************************************************
    // Counter layout
    // ****************************************************************
    localparam int unsigned CNT_W    = 32;
    localparam int unsigned AMT_W    = 5;
    localparam int unsigned SYNC_W   = 4;
    localparam int unsigned SEL_W    = 6;

    typedef enum logic [SEL_W-1:0] {
        EMSC_RX_TOO_LONG,
        EMSC_RX_ALIGN,
        EMSC_RX_OVERRUN,
        EMSC_RX_COLL,
        EMSC_RX_SHORT,
        EMSC_RX_BUF_FULL,
        EMSC_RX_MISSED,
        EMSC_RX_MAC_ERR,
        EMSC_TX_DEFER,
        EMSC_TX_SINGLE,
        EMSC_TX_MULTI,
        EMSC_TX_TOTAL,
        EMSC_TX_EXCESS,
        EMSC_TX_UNDERRUN,
        EMSC_TX_CARRIER,
        EMSC_TX_HEARTBEAT,
        EMSC_TX_LATE,
        EMSC_TX_MAC_ERR,
        EMSC_HIST_BASE
    } emsc_cnt_idx_t;

    localparam int unsigned NCNT = int'(EMSC_HIST_BASE) + HIST_BINS;

    // ****************************************************************
    // Connector type
    // ****************************************************************
    typedef enum logic [1:0] {
        EMSC_CONN_NONE,
        EMSC_CONN_AUI,
        EMSC_CONN_BNC,
        EMSC_CONN_RJ45
    } emsc_conn_t;

    // ****************************************************************
    // Event carriers from the MAC, all on the system clock
    // ****************************************************************
    typedef struct packed {
        logic        start;
        logic        done;
        logic [15:0] bytes;
        logic [2:0]  extra_bits;
        logic        overrun;
        logic        coll;
        logic        mac_err;
    } emsc_rx_ev_t;

    typedef struct packed {
        logic        req;
        logic        start;
        logic        bit_sent;
        logic        coll;
        logic        ok;
        logic        underrun;
        logic        mac_err;
    } emsc_tx_ev_t;

endpackage

// File: src/emsc_counter.sv
`timescale 1ns/100ps
`default_nettype none

module emsc_counter
(
    // Clock and control
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           ce_i,
    input  wire logic                           clear_i,
    // Increment request
    input  wire logic                           inc_i,
    input  wire logic [emsc_pkg::AMT_W-1:0]     amt_i,
    // Count
    output logic      [emsc_pkg::CNT_W-1:0]     count_o
);

    logic [emsc_pkg::CNT_W-1:0] add_w;

    assign add_w = inc_i ? {{(emsc_pkg::CNT_W-emsc_pkg::AMT_W){1'b0}}, amt_i}
                         : {emsc_pkg::CNT_W{1'b0}};

    // An event in the clearing cycle is kept as the first count.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_o <= {emsc_pkg::CNT_W{1'b0}};
        else if (ce_i)
        begin
            if (clear_i)
                count_o <= add_w;
            else
                count_o <= count_o + add_w;
        end
    end

endmodule

`default_nettype wire

// File: src/emsc_stat_top.sv
`timescale 1ns/100ps
`default_nettype none

module emsc_stat_top
(
    // Clock, reset and enable
    input  wire logic                            SYS_CLK_I,
    input  wire logic                            RESET_I,
    input  wire logic                            CE_I,
    // MAC event inputs, same clock
    input  wire emsc_pkg::emsc_rx_ev_t           RX_EV_I,
    input  wire emsc_pkg::emsc_tx_ev_t           TX_EV_I,
    input  wire logic                            BUF_FULL_I,
    input  wire logic                            CS_EN_I,
    input  wire logic                            SW_CLEAR_I,
    // Transceiver pins, asynchronous
    input  wire logic                            CRS_PIN_I,
    input  wire logic                            SQE_PIN_I,
    input  wire logic [1:0]                      CONN_PIN_I,
    // Counter readout
    input  wire logic [emsc_pkg::SEL_W-1:0]      CNT_SEL_I,
    output logic      [emsc_pkg::CNT_W-1:0]      CNT_DATA_O,
    // Status outputs
    output logic                                 TX_ABORT_O,
    output emsc_pkg::emsc_conn_t                 CONN_TYPE_O
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [emsc_pkg::SYNC_W-1:0] pin_w;
    logic [emsc_pkg::SYNC_W-1:0] s1_r;
    logic [emsc_pkg::SYNC_W-1:0] s2_r;
    logic [emsc_pkg::SYNC_W-1:0] s3_r;
    logic [emsc_pkg::SYNC_W-1:0] pin_r;

    assign pin_w = {CONN_PIN_I, SQE_PIN_I, CRS_PIN_I};

    genvar g;
    generate
        for (g = 0; g < emsc_pkg::SYNC_W; g++)
        begin : g_sync
            always_ff @(posedge SYS_CLK_I)
            begin
                if (RESET_I)
                begin
                    s1_r[g]  <= 1'b0;
                    s2_r[g]  <= 1'b0;
                    s3_r[g]  <= 1'b0;
                    pin_r[g] <= 1'b0;
                end
                else if (CE_I)
                begin
                    s1_r[g] <= pin_w[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    // A change is believed only once two stages agree.
                    if (s2_r[g] == s3_r[g])
                        pin_r[g] <= s3_r[g];
                end
            end
        end
    endgenerate

    logic crs_w;
    logic sqe_w;

    assign crs_w = pin_r[0];
    assign sqe_w = pin_r[1];

    // ****************************************************************
    // Connector type
    // ****************************************************************
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
            CONN_TYPE_O <= emsc_pkg::EMSC_CONN_NONE;
        else if (CE_I)
            CONN_TYPE_O <= emsc_pkg::emsc_conn_t'(pin_r[3:2]);
    end

    // ****************************************************************
    // Receive events
    // ****************************************************************
    logic buf_full_d_r;

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
            buf_full_d_r <= 1'b0;
        else if (CE_I)
            buf_full_d_r <= BUF_FULL_I;
    end

    // ****************************************************************
    // Transmit packet tracking
    // ****************************************************************
    logic       in_pkt_r;
    logic [4:0] coll_cnt_r;
    logic [4:0] coll_cnt_nxt;
    logic [9:0] bit_cnt_r;
    logic       defer_seen_r;
    logic       excess_w;
    logic       late_w;
    logic       carrier_w;
    logic       abort_w;
    logic       coll_w;

    assign coll_w       = TX_EV_I.coll && in_pkt_r;
    assign coll_cnt_nxt = coll_cnt_r + 5'd1;
    assign excess_w     = coll_w && (coll_cnt_nxt == emsc_pkg::MAX_COLL);
    assign late_w       = coll_w && (bit_cnt_r >= emsc_pkg::LATE_COLL_BITS);
    assign carrier_w    = coll_w && !CS_EN_I;
    assign abort_w      = excess_w || (TX_EV_I.underrun && in_pkt_r);

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            in_pkt_r   <= 1'b0;
            coll_cnt_r <= 5'd0;
        end
        else if (CE_I)
        begin
            if (TX_EV_I.start)
            begin
                in_pkt_r   <= 1'b1;
                coll_cnt_r <= 5'd0;
            end
            else if (abort_w || (TX_EV_I.ok && in_pkt_r))
                in_pkt_r <= 1'b0;
            else if (coll_w)
                coll_cnt_r <= coll_cnt_nxt;
        end
    end

    // Bits of the current attempt, saturating once late territory begins.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
            bit_cnt_r <= 10'd0;
        else if (CE_I)
        begin
            if (TX_EV_I.start || coll_w)
                bit_cnt_r <= 10'd0;
            else if (TX_EV_I.bit_sent && bit_cnt_r < emsc_pkg::LATE_COLL_BITS)
                bit_cnt_r <= bit_cnt_r + 10'd1;
        end
    end

    // One deferral per pending request, however long the line stays busy.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
            defer_seen_r <= 1'b0;
        else if (CE_I)
        begin
            if (!TX_EV_I.req)
                defer_seen_r <= 1'b0;
            else if (crs_w)
                defer_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
            TX_ABORT_O <= 1'b0;
        else if (CE_I)
            TX_ABORT_O <= abort_w;
    end

    // ****************************************************************
    // Heartbeat check after a successful send
    // ****************************************************************
    typedef enum logic [0:0] {
        HB_IDLE,
        HB_WAIT
    } emsc_hb_state_t;

    emsc_hb_state_t hb_state_r;
    logic [15:0]    hb_cnt_r;
    logic           hb_miss_w;

    assign hb_miss_w = (hb_state_r == HB_WAIT) && !sqe_w &&
                       (hb_cnt_r == 16'(emsc_pkg::HB_WINDOW_CYC - 1));

    // The packet is already counted as sent; a missing heartbeat only
    // raises the error count, since some transceivers never send one.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            hb_state_r <= HB_IDLE;
            hb_cnt_r   <= 16'h0000;
        end
        else if (CE_I)
        begin
            case (hb_state_r)
                HB_IDLE:
                begin
                    hb_cnt_r <= 16'h0000;
                    if (TX_EV_I.ok && in_pkt_r)
                        hb_state_r <= HB_WAIT;
                end
                HB_WAIT:
                begin
                    hb_cnt_r <= hb_cnt_r + 16'h0001;
                    if (sqe_w || hb_miss_w)
                        hb_state_r <= HB_IDLE;
                end
                default:
                    hb_state_r <= HB_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Counter events
    // ****************************************************************
    logic [emsc_pkg::NCNT-1:0]  inc_w;
    logic [emsc_pkg::AMT_W-1:0] amt_w [emsc_pkg::NCNT];
    logic                       tx_ok_w;
    logic                       tx_end_w;

    assign tx_ok_w  = TX_EV_I.ok && in_pkt_r;
    assign tx_end_w = tx_ok_w || abort_w;

    always_comb
    begin
        inc_w = '0;
        for (int i = 0; i < emsc_pkg::NCNT; i++)
            amt_w[i] = 5'd1;
        inc_w[emsc_pkg::EMSC_RX_TOO_LONG] = RX_EV_I.done &&
            (RX_EV_I.bytes > emsc_pkg::MAX_FRAME_BYTES);
        inc_w[emsc_pkg::EMSC_RX_ALIGN] = RX_EV_I.done &&
            (RX_EV_I.extra_bits != 3'h0);
        inc_w[emsc_pkg::EMSC_RX_OVERRUN] = RX_EV_I.overrun;
        inc_w[emsc_pkg::EMSC_RX_COLL] = RX_EV_I.coll && BUF_FULL_I;
        inc_w[emsc_pkg::EMSC_RX_SHORT] = RX_EV_I.done &&
            (RX_EV_I.bytes < emsc_pkg::MIN_FRAME_BYTES);
        inc_w[emsc_pkg::EMSC_RX_BUF_FULL] = BUF_FULL_I && !buf_full_d_r;
        inc_w[emsc_pkg::EMSC_RX_MISSED] = RX_EV_I.start && BUF_FULL_I;
        inc_w[emsc_pkg::EMSC_RX_MAC_ERR] = RX_EV_I.mac_err &&
            !(late_w || excess_w || carrier_w);
        inc_w[emsc_pkg::EMSC_TX_DEFER] = TX_EV_I.req && crs_w &&
            !defer_seen_r;
        inc_w[emsc_pkg::EMSC_TX_SINGLE] = tx_ok_w &&
            (coll_cnt_r == 5'd1);
        inc_w[emsc_pkg::EMSC_TX_MULTI] = tx_ok_w && (coll_cnt_r > 5'd1);
        // Excess aborts fold in the collision that ended the packet.
        inc_w[emsc_pkg::EMSC_TX_TOTAL] = tx_end_w;
        amt_w[emsc_pkg::EMSC_TX_TOTAL] = excess_w ? coll_cnt_nxt
                                                  : coll_cnt_r;
        inc_w[emsc_pkg::EMSC_TX_EXCESS] = excess_w;
        inc_w[emsc_pkg::EMSC_TX_UNDERRUN] = TX_EV_I.underrun &&
            in_pkt_r;
        inc_w[emsc_pkg::EMSC_TX_CARRIER] = carrier_w;
        inc_w[emsc_pkg::EMSC_TX_HEARTBEAT] = hb_miss_w;
        inc_w[emsc_pkg::EMSC_TX_LATE] = late_w;
        inc_w[emsc_pkg::EMSC_TX_MAC_ERR] = TX_EV_I.mac_err &&
            !(late_w || excess_w || carrier_w);
        for (int b = 1; b <= emsc_pkg::HIST_BINS; b++)
            inc_w[int'(emsc_pkg::EMSC_HIST_BASE) + b - 1] = tx_ok_w &&
                (coll_cnt_r == 5'(b));
    end

    // ****************************************************************
    // Counter bank and readout
    // ****************************************************************
    logic [emsc_pkg::CNT_W-1:0] cnt_w [emsc_pkg::NCNT];

    generate
        for (g = 0; g < emsc_pkg::NCNT; g++)
        begin : g_cnt
            emsc_counter u_cnt
            (
                .clk_i   (SYS_CLK_I),
                .rst_i   (RESET_I),
                .ce_i    (CE_I),
                .clear_i (SW_CLEAR_I),
                .inc_i   (inc_w[g]),
                .amt_i   (amt_w[g]),
                .count_o (cnt_w[g])
            );
        end
    endgenerate

    // Unused selections read as zero rather than aliasing a counter.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
            CNT_DATA_O <= {emsc_pkg::CNT_W{1'b0}};
        else if (CE_I)
        begin
            if (int'(CNT_SEL_I) < emsc_pkg::NCNT)
                CNT_DATA_O <= cnt_w[CNT_SEL_I];
            else
                CNT_DATA_O <= {emsc_pkg::CNT_W{1'b0}};
        end
    end

endmodule

`default_nettype wire

// File: test/emsc_props.sv
`timescale 1ns/100ps
`default_nettype none

// ************
// Port checks
// ************
module emsc_props
(
    // Clock and control
    input wire logic                       SYS_CLK_I,
    input wire logic                       RESET_I,
    input wire logic                       CE_I,
    // Events
    input wire emsc_pkg::emsc_rx_ev_t      RX_EV_I,
    input wire emsc_pkg::emsc_tx_ev_t      TX_EV_I,
    input wire logic                       BUF_FULL_I,
    input wire logic                       CS_EN_I,
    input wire logic                       SW_CLEAR_I,
    // Pins
    input wire logic                       CRS_PIN_I,
    input wire logic                       SQE_PIN_I,
    input wire logic [1:0]                 CONN_PIN_I,
    // Readout and status
    input wire logic [emsc_pkg::SEL_W-1:0] CNT_SEL_I,
    input wire logic [emsc_pkg::CNT_W-1:0] CNT_DATA_O,
    input wire logic                       TX_ABORT_O,
    input wire emsc_pkg::emsc_conn_t       CONN_TYPE_O
);
    logic       open_r;
    logic [4:0] ncoll_r;
    logic       cause;

    assign cause = CE_I && open_r && (TX_EV_I.underrun
        || TX_EV_I.coll && ncoll_r == 5'h0F);

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
            open_r <= 1'b0;
        else if (CE_I && TX_EV_I.start)
            open_r <= 1'b1;
        else if (CE_I && TX_EV_I.ok || cause)
            open_r <= 1'b0;
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RESET_I || CE_I && TX_EV_I.start)
            ncoll_r <= 5'h00;
        else if (CE_I && open_r && TX_EV_I.coll)
            ncoll_r <= ncoll_r + 5'h01;
    end

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RESET_I);

    // The heartbeat counter may move without any input, so it is left out.
    sequence quiet_s;
        CE_I && RX_EV_I == '0 && TX_EV_I == '0 && !BUF_FULL_I;
    endsequence
    sequence clear_s;
        quiet_s ##0 SW_CLEAR_I && CNT_SEL_I != emsc_pkg::EMSC_TX_HEARTBEAT
        ##1 quiet_s ##0 $stable(CNT_SEL_I);
    endsequence

    chk_reset_clear:
        assert property (disable iff (1'b0) RESET_I && CE_I |=>
            CNT_DATA_O == '0 && !TX_ABORT_O
            && CONN_TYPE_O == emsc_pkg::EMSC_CONN_NONE)
        else $error("outputs not cleared by reset");
    chk_ce_freeze:
        assert property (!CE_I |=> $stable(CNT_DATA_O)
            && $stable(TX_ABORT_O) && $stable(CONN_TYPE_O))
        else $error("outputs moved while disabled");
    chk_unmapped_zero:
        assert property (CE_I && CNT_SEL_I > 6'h20 |=> CNT_DATA_O == '0)
        else $error("unmapped index read non-zero");
    chk_conn_follow:
        assert property ((CE_I && $stable(CONN_PIN_I)) [*8] |->
            CONN_TYPE_O == emsc_pkg::emsc_conn_t'(CONN_PIN_I))
        else $error("connector type does not follow pins");
    chk_clear_zero:
        assert property (clear_s |=> CNT_DATA_O == '0)
        else $error("counter not zero after clear");
    chk_abort_under:
        assert property (cause && TX_EV_I.underrun |-> ##[1:2] TX_ABORT_O)
        else $error("no abort after underrun");
    chk_abort_excess:
        assert property (cause && TX_EV_I.coll |-> ##[1:2] TX_ABORT_O)
        else $error("no abort after sixteenth collision");
    chk_abort_cause:
        assert property ($rose(TX_ABORT_O) |-> $past(cause)
            || $past(cause, 2))
        else $error("abort without cause");
    chk_abort_pulse:
        assert property (TX_ABORT_O && CE_I |=> !TX_ABORT_O)
        else $error("abort longer than one cycle");
endmodule

bind emsc_stat_top emsc_props emsc_props_i
(
    .SYS_CLK_I, .RESET_I, .CE_I, .RX_EV_I, .TX_EV_I, .BUF_FULL_I,
    .CS_EN_I, .SW_CLEAR_I, .CRS_PIN_I, .SQE_PIN_I, .CONN_PIN_I,
    .CNT_SEL_I, .CNT_DATA_O, .TX_ABORT_O, .CONN_TYPE_O
);

`default_nettype wire

// File: test/emsc_xcvr_model.sv
`timescale 1ns/100ps
`default_nettype none

// ************
// Transceiver
// ************
module emsc_xcvr_model
(
    // Clock and commands
    input  wire logic       clk_i,
    input  wire logic       tx_ok_i,
    input  wire logic       hb_en_i,
    input  wire logic [7:0] hb_dly_i,
    input  wire logic       busy_i,
    input  wire logic [1:0] conn_i,
    // Pins
    output logic            crs_o,
    output logic            sqe_o,
    output logic [1:0]      conn_o
);
    logic [8:0] hb_cnt_r = 9'h000;

    // Heartbeat lasts six cycles after a settable delay; a unit without
    // one keeps the pin low, as some real transceivers do.
    always_ff @(posedge clk_i)
    begin
        if (tx_ok_i && hb_en_i)
            hb_cnt_r <= 9'(hb_dly_i) + 9'h006;
        else if (hb_cnt_r != 9'h000)
            hb_cnt_r <= hb_cnt_r - 9'h001;
    end

    assign sqe_o  = hb_cnt_r != 9'h000 && hb_cnt_r < 9'h007;
    assign crs_o  = busy_i;
    assign conn_o = conn_i;
endmodule

`default_nettype wire

// File: test/test_ethernet_mac_stat_counters.sv
`timescale 1ns/100ps
`default_nettype none

module test_ethernet_mac_stat_counters;
    logic                  clk, rst, ce, bf, cs_en, sw_clr, clr;
    logic                  req, busy, hb_en, crs, sqe, abort;
    emsc_pkg::emsc_rx_ev_t rx;
    emsc_pkg::emsc_tx_ev_t tx;
    logic [1:0]            conn_sel, conn_pin;
    logic [5:0]            sel;
    logic [7:0]            hb_dly;
    logic [31:0]           data;
    emsc_pkg::emsc_conn_t  conn;
    logic [31:0]           e [0:32];
    int                    err_count, check_count, n_coll, n_bits, k;
    bit                    open;
    int                    tab [4] = '{0, 1, 2, 15};
    int                    fl [5] = '{63, 64, 1518, 1519, 100};

    emsc_stat_top emsc_stat_top_i
    (
        .SYS_CLK_I(clk), .RESET_I(rst), .CE_I(ce), .RX_EV_I(rx),
        .TX_EV_I(tx), .BUF_FULL_I(bf), .CS_EN_I(cs_en),
        .SW_CLEAR_I(sw_clr), .CRS_PIN_I(crs), .SQE_PIN_I(sqe),
        .CONN_PIN_I(conn_pin), .CNT_SEL_I(sel), .CNT_DATA_O(data),
        .TX_ABORT_O(abort), .CONN_TYPE_O(conn)
    );

    emsc_xcvr_model emsc_xcvr_model_i
    (
        .clk_i(clk), .tx_ok_i(tx.ok), .hb_en_i(hb_en), .hb_dly_i(hb_dly),
        .busy_i(busy), .conn_i(conn_sel), .crs_o(crs), .sqe_o(sqe),
        .conn_o(conn_pin)
    );

    // ************
    // Tasks
    // ************
    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_cnt(input logic [31:0] got, want);
        check_count++;
        if (got !== want)
        begin
            err_count++;
            $display("wrong value at %0t: count %h not %h", $time, got, want);
        end
    endtask

    task automatic chk_out(input logic [1:0] got, want);
        check_count++;
        if (got !== want)
        begin
            err_count++;
            $display("wrong value at %0t: status %h not %h", $time, got, want);
        end
    endtask

    // Reference model of every counter but indexes 5 and 8, updated for what the next edge takes.
    task automatic model();
        bit sp;
        if (clr)
            foreach (e[i]) e[i] = 32'h0;
        sp = open && tx.coll && (n_bits >= emsc_pkg::LATE_COLL_BITS
            || !cs_en || n_coll == 15);
        e[0] += rx.done && rx.bytes > emsc_pkg::MAX_FRAME_BYTES;
        e[1] += rx.done && rx.extra_bits != 3'h0;
        e[2] += rx.overrun;
        e[3] += rx.coll && bf;
        e[4] += rx.done && rx.bytes < emsc_pkg::MIN_FRAME_BYTES;
        e[6] += rx.start && bf;
        e[7] += rx.mac_err && !sp;
        e[17] += tx.mac_err && !sp;
        n_bits += open && tx.bit_sent;
        if (open && tx.coll)
        begin
            e[16] += n_bits >= emsc_pkg::LATE_COLL_BITS;
            e[14] += !cs_en;
            n_coll++;
            n_bits = 0;
        end
        if (open && (tx.ok || tx.underrun || n_coll == emsc_pkg::MAX_COLL))
        begin
            e[11] += n_coll;
            e[9] += tx.ok && n_coll == 1;
            e[10] += tx.ok && n_coll > 1;
            e[12] += n_coll == emsc_pkg::MAX_COLL;
            e[13] += tx.underrun;
            e[15] += tx.ok && !hb_en;
            if (tx.ok && n_coll > 0)
                e[17 + n_coll]++;
            open = 0;
        end
        if (tx.start)
        begin
            open = 1;
            n_coll = 0;
            n_bits = 0;
        end
    endtask

    // Drives one cycle of events at the falling edge.
    task automatic fire(input logic [23:0] r, input logic [6:0] t);
        @(negedge clk);
        rx = emsc_pkg::emsc_rx_ev_t'(r);
        tx = emsc_pkg::emsc_tx_ev_t'(t | {req, 6'h00});
        sw_clr = clr;
        if (ce)
            model();
        clr = 0;
    endtask

    task automatic idle(input int n);
        repeat (n) fire(24'h0, 7'h00);
    endtask

    task automatic rxf(input int b, input int x);
        fire({2'h1, 16'(b), 3'(x), 3'h0}, 7'h00);
    endtask

    task automatic wait_abort();
        for (int i = 0; i < 3 && abort !== 1'b1; i++) fire(24'h0, 7'h00);
        chk_out({1'b0, abort}, 2'h1);
        if (abort !== 1'b1)
            stop_test();
    endtask

    task automatic pkt(input int n, input int b, input logic [6:0] fin);
        fire(24'h0, 7'h20);
        repeat (n)
        begin
            repeat (b) fire(24'h0, 7'h10);
            fire(24'h0, 7'h08);
        end
        fire(24'h0, fin);
        if (fin != 7'h04)
            wait_abort();
        idle(60);
    endtask

    // Index 33 stands for an unmapped select, which must read zero.
    task automatic check_all();
        for (int i = 0; i < 34; i++)
        begin
            sel = 6'(i == 33 ? 40 : i);
            idle(2);
            chk_cnt(data, i == 33 ? 32'h0 : e[i]);
        end
    endtask

    // ************
    // Sequence
    // ************
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        {rst, ce, bf, cs_en, sw_clr, clr, req, busy, hb_en} = 9'h1A1;
        {sel, conn_sel, hb_dly, open} = '0;
        {err_count, check_count, n_coll, n_bits} = '0;
        rx = '0;
        tx = '0;
        foreach (e[i]) e[i] = 32'h0;
        void'($urandom(66752));
        repeat (20) @(negedge clk);
        rst = 0;
        check_all();
        foreach (fl[i]) rxf(fl[i], i);
        repeat (20) rxf($urandom_range(2000), $urandom_range(7));
        fire(24'h000004, 7'h00);
        bf = 1;
        e[5]++;
        fire(24'h800002, 7'h00);
        // Levels change after a quiet edge, so the model sees what the edge sees.
        idle(1);
        bf = 0;
        fire(24'h800002, 7'h00);
        idle(2);
        check_all();
        foreach (tab[i]) pkt(tab[i], 2, 7'h04);
        repeat (4)
        begin
            hb_dly = 8'($urandom_range(1, 40));
            pkt($urandom_range(1, 15), 2, 7'h04);
        end
        pkt(15, 1, 7'h08);
        fire(24'h0, 7'h0D);
        pkt(3, 1, 7'h02);
        pkt(1, 511, 7'h04);
        pkt(1, 512, 7'h04);
        cs_en = 0;
        fire(24'h0, 7'h20);
        fire(24'h000001, 7'h09);
        fire(24'h000001, 7'h05);
        idle(60);
        cs_en = 1;
        hb_en = 0;
        pkt(0, 2, 7'h04);
        idle(420);
        hb_en = 1;
        check_all();
        busy = 1;
        idle(8);
        req = 1;
        idle(20);
        req = 0;
        idle(2);
        req = 1;
        idle(20);
        req = 0;
        busy = 0;
        e[8] += 2;
        idle(8);
        clr = 1;
        fire(24'h000004, 7'h00);
        idle(1);
        ce = 0;
        fire(24'h000007, 7'h3F);
        idle(1);
        ce = 1;
        idle(2);
        check_all();
        pkt(2, 1, 7'h04);
        sel = 6'(emsc_pkg::EMSC_TX_TOTAL);
        clr = 1;
        idle(3);
        chk_cnt(data, e[11]);
        for (k = 0; k < 4; k++)
        begin
            conn_sel = 2'(k);
            idle(10);
            chk_out(conn, 2'(k));
        end
        stop_test();
    end
endmodule

`default_nettype wire
